// file: ar_address_resolver.sv
`timescale 1ns/1ps
`include "ar_defines.svh"

// Notes on behaviour
// RULE_01 - the address is six bytes: three hash bytes then three random bytes
// RULE_02 - software loads the address pointer with the packet start before starting
// RULE_03 - a start task begins one resolution procedure
// RULE_04 - a match event is raised when a key resolves the address
// RULE_05 - keys are tried in ascending order from key zero, sixteen at most
// RULE_06 - key count sets how many keys from the table start are used
// RULE_07 - a no-match event is raised when no key resolves the address
// RULE_08 - each key hashes the random part and compares with the hash part
// RULE_09 - the address type bits are never examined
// RULE_10 - stop on first match or after the counted keys are exhausted
// RULE_11 - a completion event follows every finished procedure, matched or not
// RULE_12 - all memory accesses are over before any event is raised
// RULE_13 - software keeps all three pointers inside data memory
// RULE_14 - one cipher core is shared with the ccm and block-cipher engines
// RULE_15 - the block-cipher engine always has the lowest core priority
// RULE_16 - a core conflict aborts the block cipher and raises its abort event
// RULE_17 - latency grows with key position and with memory contention
// RULE_18 - key n is sixteen bytes at the key table pointer plus sixteen times n
// RULE_19 - with the radio, start once the six address bytes are in memory
// RULE_20 - a stop task aborts the procedure and leaves the block idle
module ar_address_resolver (
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	// tasks and configuration
	input  wire logic              start_task_i,
	input  wire logic              stop_task_i,
	input  wire logic [4:0]        key_count_i,
	input  wire logic [31:0]       key_table_pointer_i,
	input  wire logic [31:0]       address_pointer_i,
	input  wire logic [31:0]       scratch_pointer_i,
	// events and status
	output logic                   end_event_o,
	output logic                   match_event_o,
	output logic                   no_match_event_o,
	output logic                   busy_o,
	output logic [3:0]             match_index_o,
	// memory master
	output logic                   dma_req_o,
	output logic                   dma_we_o,
	output logic [31:0]            dma_addr_o,
	output logic [31:0]            dma_wdata_o,
	input  wire logic              dma_ack_i,
	input  wire logic [31:0]       dma_rdata_i,
	// other cipher users
	input  wire logic              ccm_req_i,
	input  wire ar_pkg::ar_block_t ccm_key_i,
	input  wire ar_pkg::ar_block_t ccm_data_i,
	output logic                   ccm_done_o,
	input  wire logic              ecb_req_i,
	input  wire ar_pkg::ar_block_t ecb_key_i,
	input  wire ar_pkg::ar_block_t ecb_data_i,
	output logic                   ecb_done_o,
	output logic                   block_cipher_abort_event_o,
	output ar_pkg::ar_block_t      user_result_o,
	// shared cipher core
	output logic                   aes_start_o,
	output logic                   aes_abort_o,
	output ar_pkg::ar_block_t      aes_key_o,
	output ar_pkg::ar_block_t      aes_data_o,
	input  wire logic              aes_done_i,
	input  wire ar_pkg::ar_block_t aes_result_i
);
	import ar_pkg::*;

	ar_state_t             state_r;
	logic      [1:0]       word_r;
	logic      [4:0]       key_idx_r;
	logic      [4:0]       count_r;
	logic      [31:0]      kptr_r;
	logic      [31:0]      sptr_r;
	logic      [1:0]       aoff_r;
	logic      [95:0]      abuf_r;
	ar_block_t             key_r;
	logic                  hit_r;
	logic                  res_req_r;
	logic                  stop_pend_r;
	logic                  res_done;
	logic [`AR_HASH_W-1:0] hash_part;
	logic [`AR_HASH_W-1:0] prand;
	ar_block_t             res_data;
	logic                  key_last;
	logic                  stopping;

	function automatic logic [7:0] ar_byte(input logic [95:0] b, input logic [1:0] off,
		input logic [2:0] i);
		logic [95:0] t;
		t       = b >> ({2'b0, off, 3'b0} + {1'b0, i, 3'b0});
		ar_byte = t[7:0];
	endfunction : ar_byte

	function automatic logic [31:0] ar_bswap(input logic [31:0] w);
		ar_bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : ar_bswap

	function automatic logic [31:0] ar_key_addr(input logic [31:0] base, input logic [4:0] idx);
		ar_key_addr = base + {23'h0, idx, 4'h0};
	endfunction : ar_key_addr

	// ************************************************************
	// address split and hash input
	// ************************************************************
	always_comb begin
		// byte 0 is the least significant hash byte; type bits are not checked
		hash_part = {ar_byte(abuf_r, aoff_r, 3'd2), ar_byte(abuf_r, aoff_r, 3'd1),
			ar_byte(abuf_r, aoff_r, 3'd0)}; // see RULE_01 see RULE_09
		prand     = {ar_byte(abuf_r, aoff_r, 3'd5), ar_byte(abuf_r, aoff_r, 3'd4),
			ar_byte(abuf_r, aoff_r, 3'd3)};
		res_data  = {`AR_PAD_ZEROS, prand}; // see RULE_08
		key_last  = (key_idx_r + 5'd1) == count_r;
		stopping  = (stop_task_i || stop_pend_r) && (state_r != AR_ST_IDLE);
	end

	// ************************************************************
	// configuration captured at start
	// ************************************************************
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_r <= '0;
			kptr_r  <= '0;
			sptr_r  <= '0;
			aoff_r  <= '0;
		end else if ((state_r == AR_ST_IDLE) && start_task_i && !stop_task_i) begin
			count_r <= (key_count_i > `AR_MAX_KEYS) ? `AR_MAX_KEYS : key_count_i; // see RULE_06
			kptr_r  <= key_table_pointer_i;
			sptr_r  <= scratch_pointer_i;
			aoff_r  <= address_pointer_i[1:0]; // see RULE_02
		end
	end

	// ************************************************************
	// procedure sequencer and memory master
	// ************************************************************
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r     <= AR_ST_IDLE;
			word_r      <= '0;
			key_idx_r   <= '0;
			res_req_r   <= 1'b0;
			stop_pend_r <= 1'b0;
			dma_req_o   <= 1'b0;
			dma_we_o    <= 1'b0;
			dma_addr_o  <= '0;
			dma_wdata_o <= '0;
		end else if (stopping) begin
			// a bus access in flight must end before the block goes idle
			res_req_r <= 1'b0; // see RULE_20
			if (dma_req_o && !dma_ack_i) begin
				stop_pend_r <= 1'b1;
			end else begin
				state_r     <= AR_ST_IDLE;
				dma_req_o   <= 1'b0;
				dma_we_o    <= 1'b0;
				stop_pend_r <= 1'b0;
			end
		end else begin
			case (state_r)
				AR_ST_IDLE: begin
					if (start_task_i && !stop_task_i) begin
						state_r    <= AR_ST_ADDR; // see RULE_03
						word_r     <= '0;
						key_idx_r  <= '0;
						dma_req_o  <= 1'b1;
						dma_we_o   <= 1'b0;
						dma_addr_o <= {address_pointer_i[31:2], 2'b00};
					end
				end
				AR_ST_ADDR: begin
					if (dma_ack_i) begin // see RULE_17
						if (word_r == `AR_ADDR_LAST_W) begin
							word_r <= '0;
							if (count_r == 5'd0) begin
								dma_req_o <= 1'b0;
								state_r   <= AR_ST_DONE;
							end else begin
								state_r    <= AR_ST_KEY;
								dma_addr_o <= ar_key_addr(kptr_r, 5'd0); // see RULE_05
							end
						end else begin
							word_r     <= word_r + 2'd1;
							dma_addr_o <= dma_addr_o + `AR_WORD_STEP;
						end
					end
				end
				AR_ST_KEY: begin
					if (dma_ack_i) begin
						if (word_r == `AR_KEY_LAST_W) begin
							word_r    <= '0;
							dma_req_o <= 1'b0;
							res_req_r <= 1'b1;
							state_r   <= AR_ST_AES;
						end else begin
							word_r     <= word_r + 2'd1;
							dma_addr_o <= dma_addr_o + `AR_WORD_STEP; // see RULE_18
						end
					end
				end
				AR_ST_AES: begin
					if (res_done) begin
						res_req_r   <= 1'b0;
						state_r     <= AR_ST_SCR;
						dma_req_o   <= 1'b1;
						dma_we_o    <= 1'b1;
						dma_addr_o  <= sptr_r;
						dma_wdata_o <= {8'h0, user_result_o[`AR_HASH_W-1:0]};
					end
				end
				AR_ST_SCR: begin
					if (dma_ack_i) begin
						dma_we_o <= 1'b0;
						if (hit_r || key_last) begin
							dma_req_o <= 1'b0; // see RULE_10 see RULE_12
							state_r   <= AR_ST_DONE;
						end else begin
							key_idx_r  <= key_idx_r + 5'd1; // see RULE_05
							state_r    <= AR_ST_KEY;
							dma_addr_o <= ar_key_addr(kptr_r, key_idx_r + 5'd1);
						end
					end
				end
				AR_ST_DONE: begin
					state_r <= AR_ST_IDLE;
				end
				default: begin
					state_r <= AR_ST_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// captured address, key and verdict
	// ************************************************************
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			abuf_r <= '0;
			key_r  <= '0;
			hit_r  <= 1'b0;
		end else begin
			if ((state_r == AR_ST_IDLE) && start_task_i) begin
				hit_r <= 1'b0;
			end
			if ((state_r == AR_ST_ADDR) && dma_ack_i) begin
				abuf_r[{word_r, 5'b0} +: 32] <= dma_rdata_i;
			end
			if ((state_r == AR_ST_KEY) && dma_ack_i) begin
				// first key byte in memory is the most significant
				key_r[{~word_r, 5'b0} +: 32] <= ar_bswap(dma_rdata_i);
			end
			if ((state_r == AR_ST_AES) && res_done) begin
				hit_r <= (user_result_o[`AR_HASH_W-1:0] == hash_part); // see RULE_08
			end
		end
	end

	// ************************************************************
	// events and status
	// ************************************************************
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			end_event_o      <= 1'b0;
			match_event_o    <= 1'b0;
			no_match_event_o <= 1'b0;
			busy_o           <= 1'b0;
			match_index_o    <= '0;
		end else begin
			end_event_o      <= (state_r == AR_ST_DONE) && !stopping; // see RULE_11
			match_event_o    <= (state_r == AR_ST_DONE) && !stopping && hit_r; // see RULE_04
			no_match_event_o <= (state_r == AR_ST_DONE) && !stopping && !hit_r; // see RULE_07
			busy_o           <= (state_r != AR_ST_IDLE) && !(stopping && !dma_req_o);
			if ((state_r == AR_ST_DONE) && hit_r) begin
				match_index_o <= key_idx_r[3:0];
			end
		end
	end

	ar_aes_arbiter u_arbiter ( // see RULE_14
		.clk_sys_i    (clk_sys_i),
		.reset_n_i    (reset_n_i),
		.ccm_req_i    (ccm_req_i),
		.ccm_key_i    (ccm_key_i),
		.ccm_data_i   (ccm_data_i),
		.ccm_done_o   (ccm_done_o),
		.res_req_i    (res_req_r),
		.res_key_i    (key_r),
		.res_data_i   (res_data),
		.res_done_o   (res_done),
		.ecb_req_i    (ecb_req_i),
		.ecb_key_i    (ecb_key_i),
		.ecb_data_i   (ecb_data_i),
		.ecb_done_o   (ecb_done_o),
		.ecb_abort_o  (block_cipher_abort_event_o),
		.aes_start_o  (aes_start_o),
		.aes_abort_o  (aes_abort_o),
		.aes_key_o    (aes_key_o),
		.aes_data_o   (aes_data_o),
		.aes_done_i   (aes_done_i),
		.aes_result_i (aes_result_i),
		.result_o     (user_result_o)
	);

	// ************************************************************
	// checks
	// ************************************************************
	end_pairs_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		end_event_o |-> (match_event_o ^ no_match_event_o)) // see RULE_11
		else $error("end without exactly one verdict");
	verdict_end_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(match_event_o || no_match_event_o) |-> end_event_o) // see RULE_04
		else $error("verdict without end");
	bus_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		end_event_o |-> !dma_req_o && !$past(dma_req_o)) // see RULE_12
		else $error("memory access open at event");
	start_read_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(state_r == AR_ST_IDLE) && start_task_i && !stop_task_i |=> dma_req_o && !dma_we_o
		&& (dma_addr_o == {$past(address_pointer_i[31:2]), 2'b00})) // see RULE_03
		else $error("start did not read the address");
	key_addr_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(state_r == AR_ST_KEY) && dma_req_o |-> dma_addr_o == ar_key_addr(kptr_r, key_idx_r)
		+ {28'h0, word_r, 2'b00}) // see RULE_18
		else $error("key word address wrong");
	key_step_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(state_r == AR_ST_SCR) && dma_ack_i && !hit_r && !key_last && !stopping
		|=> (key_idx_r == $past(key_idx_r) + 5'd1) && (state_r == AR_ST_KEY)) // see RULE_05
		else $error("keys not tried in order");
	hit_stops_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(state_r == AR_ST_SCR) && dma_ack_i && hit_r && !stopping
		|=> (state_r == AR_ST_DONE) ##1 match_event_o) // see RULE_10
		else $error("match did not stop the search");
	stop_idle_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		stop_task_i && !dma_req_o |=> (state_r == AR_ST_IDLE) && !end_event_o
		&& !res_req_r) // see RULE_20
		else $error("stop did not idle the block");
endmodule : ar_address_resolver

// file: ar_aes_arbiter.sv
`timescale 1ns/1ps
`include "ar_defines.svh"

module ar_aes_arbiter (
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	// users, highest priority first
	input  wire logic              ccm_req_i,
	input  wire ar_pkg::ar_block_t ccm_key_i,
	input  wire ar_pkg::ar_block_t ccm_data_i,
	output logic                   ccm_done_o,
	input  wire logic              res_req_i,
	input  wire ar_pkg::ar_block_t res_key_i,
	input  wire ar_pkg::ar_block_t res_data_i,
	output logic                   res_done_o,
	input  wire logic              ecb_req_i,
	input  wire ar_pkg::ar_block_t ecb_key_i,
	input  wire ar_pkg::ar_block_t ecb_data_i,
	output logic                   ecb_done_o,
	output logic                   ecb_abort_o,
	// shared core
	output logic                   aes_start_o,
	output logic                   aes_abort_o,
	output ar_pkg::ar_block_t      aes_key_o,
	output ar_pkg::ar_block_t      aes_data_o,
	input  wire logic              aes_done_i,
	input  wire ar_pkg::ar_block_t aes_result_i,
	output ar_pkg::ar_block_t      result_o
);
	import ar_pkg::*;

	ar_owner_t owner_r;
	logic      run_r;
	logic      owner_req;
	logic      preempt;
	logic      grant;
	logic      done_ok;

	function automatic logic ar_req_of(input ar_owner_t o, input logic c, input logic r,
		input logic e);
		case (o)
			AR_OWN_CCM: ar_req_of = c;
			AR_OWN_RES: ar_req_of = r;
			AR_OWN_ECB: ar_req_of = e;
			default:    ar_req_of = 1'b0;
		endcase
	endfunction : ar_req_of

	always_comb begin
		owner_req = ar_req_of(owner_r, ccm_req_i, res_req_i, ecb_req_i);
		grant     = (owner_r == AR_OWN_NONE) && (ccm_req_i || res_req_i || ecb_req_i);
		preempt   = (owner_r == AR_OWN_ECB) && run_r && (ccm_req_i || res_req_i); // see RULE_16
		done_ok   = aes_done_i && run_r && owner_req && !preempt;
	end

	// ************************************************************
	// ownership of the core
	// ************************************************************
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			owner_r     <= AR_OWN_NONE;
			run_r       <= 1'b0;
			aes_start_o <= 1'b0;
			aes_abort_o <= 1'b0;
			ecb_abort_o <= 1'b0;
		end else begin
			aes_start_o <= 1'b0;
			aes_abort_o <= 1'b0;
			ecb_abort_o <= 1'b0;
			if (grant) begin
				// fixed priority, block cipher last
				owner_r     <= ccm_req_i ? AR_OWN_CCM : (res_req_i ? AR_OWN_RES : AR_OWN_ECB); // see RULE_15
				run_r       <= 1'b1;
				aes_start_o <= 1'b1;
			end else if (preempt) begin
				owner_r     <= AR_OWN_NONE; // see RULE_16
				run_r       <= 1'b0;
				aes_abort_o <= 1'b1;
				ecb_abort_o <= 1'b1;
			end else if ((owner_r != AR_OWN_NONE) && !owner_req) begin
				owner_r     <= AR_OWN_NONE;
				run_r       <= 1'b0;
				aes_abort_o <= run_r;
			end else if (done_ok) begin
				run_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aes_key_o  <= '0;
			aes_data_o <= '0;
		end else if (grant) begin
			aes_key_o  <= ccm_req_i ? ccm_key_i : (res_req_i ? res_key_i : ecb_key_i);
			aes_data_o <= ccm_req_i ? ccm_data_i : (res_req_i ? res_data_i : ecb_data_i);
		end
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ccm_done_o <= 1'b0;
			res_done_o <= 1'b0;
			ecb_done_o <= 1'b0;
			result_o   <= '0;
		end else begin
			ccm_done_o <= done_ok && (owner_r == AR_OWN_CCM);
			res_done_o <= done_ok && (owner_r == AR_OWN_RES);
			ecb_done_o <= done_ok && (owner_r == AR_OWN_ECB);
			if (done_ok) begin
				result_o <= aes_result_i;
			end
		end
	end

	ccm_first_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(owner_r == AR_OWN_NONE) && ccm_req_i |=> (owner_r == AR_OWN_CCM) && aes_start_o) // see RULE_15
		else $error("ccm request not granted first");
	ecb_yield_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		preempt |=> ecb_abort_o && aes_abort_o && (owner_r == AR_OWN_NONE)) // see RULE_16
		else $error("block cipher not aborted on conflict");

endmodule : ar_aes_arbiter

// file: ar_defines.svh
`ifndef AR_DEFINES_SVH
`define AR_DEFINES_SVH

// ************************************************************
// resolver geometry
// ************************************************************
`define AR_ADDR_BYTES    6
`define AR_ADDR_LAST_W   2'd2
`define AR_KEY_LAST_W    2'd3
`define AR_KEY_SHIFT     4
`define AR_MAX_KEYS      5'd16
`define AR_HASH_W        24
`define AR_WORD_STEP     32'h4
`define AR_PAD_ZEROS     104'h0

`endif

// file: ar_pkg.sv
package ar_pkg;

	typedef logic [127:0] ar_block_t;

	typedef enum logic [2:0] {
		AR_ST_IDLE,
		AR_ST_ADDR,
		AR_ST_KEY,
		AR_ST_AES,
		AR_ST_SCR,
		AR_ST_DONE
	} ar_state_t;

	typedef enum logic [1:0] {
		AR_OWN_NONE,
		AR_OWN_CCM,
		AR_OWN_RES,
		AR_OWN_ECB
	} ar_owner_t;

endpackage : ar_pkg

// file: ar_tb_partner.sv
`timescale 1ns/1ps

module ar_tb_partner (
	// clock, reset and pacing
	input  wire logic              clk_sys_i,
	input  wire logic              reset_n_i,
	input  wire logic              slow_i,
	// memory side
	input  wire logic              dma_req_i,
	input  wire logic              dma_we_i,
	input  wire logic [31:0]       dma_addr_i,
	input  wire logic [31:0]       dma_wdata_i,
	output logic                   dma_ack_o,
	output logic [31:0]            dma_rdata_o,
	// cipher core side
	input  wire logic              aes_start_i,
	input  wire logic              aes_abort_i,
	input  wire ar_pkg::ar_block_t aes_key_i,
	input  wire ar_pkg::ar_block_t aes_data_i,
	output logic                   aes_done_o,
	output ar_pkg::ar_block_t      aes_result_o
);
	import ar_pkg::*;
	logic [31:0] mem [0:127];
	int          wr_count;
	int          mem_cnt;
	int          aes_cnt;
	logic        aes_run;
	ar_block_t   aes_val;

	// ************
	// data memory
	// ************
	// slow pacing stands for other masters holding the memory
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dma_ack_o <= 1'b0;
			dma_rdata_o <= 32'h0;
			mem_cnt <= 0;
			wr_count <= 0;
		end else if (dma_req_i && !dma_ack_o && mem_cnt >= (slow_i ? 5 : 1)) begin
			dma_ack_o <= 1'b1;
			mem_cnt <= 0;
			dma_rdata_o <= mem[dma_addr_i[8:2]];
			if (dma_we_i) begin
				mem[dma_addr_i[8:2]] <= dma_wdata_i;
				wr_count <= wr_count + 1;
			end
		end else begin
			dma_ack_o <= 1'b0;
			dma_rdata_o <= ~dma_rdata_o;
			mem_cnt <= (dma_req_i && !dma_ack_o) ? mem_cnt + 1 : 0;
		end
	end

	// ************
	// cipher core
	// ************
	// stand-in cipher: key xor block, result bus toggles when not valid
	always @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aes_done_o <= 1'b0;
			aes_run <= 1'b0;
			aes_cnt <= 0;
			aes_result_o <= '0;
		end else begin
			aes_done_o <= 1'b0;
			aes_result_o <= ~aes_result_o;
			if (aes_abort_i) begin
				aes_run <= 1'b0;
			end else if (aes_start_i) begin
				aes_run <= 1'b1;
				aes_cnt <= 0;
				aes_val <= aes_key_i ^ aes_data_i;
			end else if (aes_run) begin
				aes_cnt <= aes_cnt + 1;
				if (aes_cnt >= (slow_i ? 30 : 2)) begin
					aes_run <= 1'b0;
					aes_done_o <= 1'b1;
					aes_result_o <= aes_val;
				end
			end
		end
	end
endmodule : ar_tb_partner

// file: tb.sv
`timescale 1ns/1ps

module tb;
	import ar_pkg::*;
	typedef struct {logic [4:0] kc; int m; logic slow; logic hit; int wr;} ar_row_t;
	localparam logic [23:0] PRAND = 24'h123456;
	logic        clk_sys_i = 1'b0, reset_n_i = 1'b0, slow = 1'b0;
	logic        start_task_i = 1'b0, stop_task_i = 1'b0, ccm_req_i = 1'b0, ecb_req_i = 1'b0;
	logic [4:0]  key_count_i = 5'h0;
	logic [31:0] key_table_pointer_i = 32'h100, address_pointer_i = 32'h11;
	logic [31:0] scratch_pointer_i = 32'h20, dma_addr_o, dma_wdata_o, dma_rdata_i;
	logic        end_event_o, match_event_o, no_match_event_o, busy_o, dma_req_o, dma_we_o;
	logic        dma_ack_i, ccm_done_o, ecb_done_o, block_cipher_abort_event_o;
	logic        aes_start_o, aes_abort_o, aes_done_i;
	logic [3:0]  match_index_o;
	ar_block_t   ccm_key_i = 128'h11, ccm_data_i = 128'h2200;
	ar_block_t   ecb_key_i = 128'h3, ecb_data_i = 128'h40;
	ar_block_t   user_result_o, aes_key_o, aes_data_o, aes_result_i;
	int          err_total = 0, n_tests = 0, aborts = 0, core_aborts = 0, i;
	ar_row_t     rows [7] = '{'{1, 0, 0, 1, 1}, '{16, 15, 0, 1, 16}, '{16, 16, 0, 0, 16},
		'{3, 5, 1, 0, 3}, '{4, 2, 0, 1, 3}, '{0, 0, 0, 0, 0}, '{20, 15, 0, 1, 16}};

	ar_address_resolver i_ar_address_resolver (.clk_sys_i, .reset_n_i, .start_task_i,
		.stop_task_i, .key_count_i, .key_table_pointer_i, .address_pointer_i,
		.scratch_pointer_i, .end_event_o, .match_event_o, .no_match_event_o, .busy_o,
		.match_index_o, .dma_req_o, .dma_we_o, .dma_addr_o, .dma_wdata_o, .dma_ack_i,
		.dma_rdata_i, .ccm_req_i, .ccm_key_i, .ccm_data_i, .ccm_done_o, .ecb_req_i, .ecb_key_i,
		.ecb_data_i, .ecb_done_o, .block_cipher_abort_event_o, .user_result_o, .aes_start_o,
		.aes_abort_o, .aes_key_o, .aes_data_o, .aes_done_i, .aes_result_i);
	ar_tb_partner i_ar_tb_partner (.clk_sys_i, .reset_n_i, .slow_i(slow), .dma_req_i(dma_req_o),
		.dma_we_i(dma_we_o), .dma_addr_i(dma_addr_o), .dma_wdata_i(dma_wdata_o),
		.dma_ack_o(dma_ack_i), .dma_rdata_o(dma_rdata_i), .aes_start_i(aes_start_o),
		.aes_abort_i(aes_abort_o), .aes_key_i(aes_key_o), .aes_data_i(aes_data_o),
		.aes_done_o(aes_done_i), .aes_result_o(aes_result_i));

	always #2 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (block_cipher_abort_event_o === 1'b1) aborts++;
	always @(posedge clk_sys_i) if (aes_abort_o === 1'b1) core_aborts++;

	// ************
	// helpers
	// ************
	function automatic logic [23:0] kv(input int n);
		return 24'h0a0b0c + 24'h010101 * n[23:0];
	endfunction : kv

	task automatic test_done;
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	// samples at the edge, so the value seen is the one the design also samples
	task automatic wait_on(input int sel);
		logic hit;
		for (int k = 0; k < 3000; k++) begin
			@(posedge clk_sys_i);
			case (sel)
				0: hit = end_event_o;
				1: hit = block_cipher_abort_event_o;
				2: hit = ccm_done_o;
				3: hit = ecb_done_o;
				default: hit = ~busy_o;
			endcase
			if (hit === 1'b1) return;
		end
		err_total++;
		$display("[ERR] wait %0d expected event seen none", sel);
		test_done;
	endtask : wait_on

	// key n low bytes sit in its last word; address hash picks key m, m=16 picks none
	task automatic load(input int m);
		logic [23:0] k, h;
		for (int n = 0; n < 16; n++) begin
			k = kv(n);
			for (int w = 0; w < 3; w++) i_ar_tb_partner.mem[64 + 4 * n + w] = 32'h0;
			i_ar_tb_partner.mem[67 + 4 * n] = {k[7:0], k[15:8], k[23:16], 8'h00};
		end
		h = (m < 16) ? (kv(m) ^ PRAND) : 24'hffffff;
		i_ar_tb_partner.mem[4] = {h, 8'hc3};
		i_ar_tb_partner.mem[5] = {8'hc3, PRAND};
		i_ar_tb_partner.mem[6] = 32'hc3c3c3c3;
	endtask : load

	task automatic kick(input logic [4:0] kc, input int m, input logic s);
		load(m);
		@(posedge clk_sys_i);
		slow <= s;
		key_count_i <= kc;
		start_task_i <= 1'b1;
		@(posedge clk_sys_i);
		start_task_i <= 1'b0;
	endtask : kick

	task automatic run_case(input ar_row_t r);
		int wr0;
		wr0 = i_ar_tb_partner.wr_count;
		kick(r.kc, r.m, r.slow);
		wait_on(0);
		chk("match", r.hit, match_event_o);
		chk("no_match", !r.hit, no_match_event_o);
		chk("dma_idle", 1'b0, dma_req_o);
		chk("writes", r.wr, i_ar_tb_partner.wr_count - wr0);
		if (r.hit) chk("index", r.wr - 1, match_index_o);
		if (r.wr > 0) chk("scratch", {8'h0, kv(r.wr-1) ^ PRAND}, i_ar_tb_partner.mem[8]);
	endtask : run_case

	// ************
	// sequence
	// ************
	initial begin
		int n_end;
		repeat (3) @(posedge clk_sys_i);
		chk("reset_req", 1'b0, dma_req_o);
		chk("reset_end", 1'b0, end_event_o);
		repeat (3) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		$display("test reset done");
		for (i = 0; i < 7; i++) run_case(rows[i]);
		$display("test table done");
		kick(16, 16, 1'b1);
		repeat (40) @(posedge clk_sys_i);
		stop_task_i <= 1'b1;
		wait_on(4);
		stop_task_i <= 1'b0;
		n_end = 0;
		repeat (60) @(posedge clk_sys_i) if (end_event_o === 1'b1) n_end++;
		chk("stop_no_end", 0, n_end);
		run_case(rows[4]);
		$display("test stop done");
		kick(1, 0, 1'b1);
		repeat (30) @(posedge clk_sys_i);
		ecb_req_i <= 1'b1;
		wait_on(1);
		ecb_req_i <= 1'b0;
		wait_on(0);
		chk("conflict_match", 1'b1, match_event_o);
		$display("test conflict done");
		n_end = aborts;
		@(posedge clk_sys_i);
		slow <= 1'b0;
		ccm_req_i <= 1'b1;
		ecb_req_i <= 1'b1;
		wait_on(2);
		ccm_req_i <= 1'b0;
		@(posedge clk_sys_i);
		chk("ccm_result", ccm_key_i ^ ccm_data_i, user_result_o);
		wait_on(3);
		ecb_req_i <= 1'b0;
		@(posedge clk_sys_i);
		chk("ecb_result", ecb_key_i ^ ecb_data_i, user_result_o);
		chk("ecb_aborts", n_end, aborts);
		chk("core_aborts", 1, core_aborts);
		$display("test priority done");
		test_done;
	end
endmodule : tb
